// [scid_consts.vh]
`ifndef SCID_CONSTS_VH
`define SCID_CONSTS_VH
`define SCID_OP_JUMP_ALWAYS    5'h00
`define SCID_OP_SUB_EXIT       5'h01
`define SCID_OP_JUMP_IF_ZERO   5'h02
`define SCID_OP_JUMP_IF_CARRY  5'h03
`define SCID_OP_LOOP_NEXT      5'h05
`define SCID_OP_IRQ_ENABLE     5'h06
`define SCID_OP_LOAD_ADDR_INC  5'h09
`define SCID_OP_LOAD_LITERAL   5'h0a
`define SCID_OP_LOAD_VIA_ADDR  5'h0b
`define SCID_OP_WRITE_ADDR_INC 5'h0d
`define SCID_OP_BYTE_ROTATE    5'h0e
`define SCID_OP_WRITE_VIA_ADDR 5'h0f
`define SCID_OP_INVERT_TOP     5'h10
`define SCID_OP_SHIFT_UP       5'h11
`define SCID_OP_SHIFT_DOWN     5'h12
`define SCID_OP_PRODUCT_STEP   5'h13
`define SCID_OP_XOR            5'h14
`define SCID_OP_AND            5'h15
`define SCID_OP_QUOTIENT_STEP  5'h16
`define SCID_OP_ADD            5'h17
`define SCID_OP_RET_TO_TOP     5'h18
`define SCID_OP_ADDR_TO_TOP    5'h19
`define SCID_OP_COPY_TOP       5'h1a
`define SCID_OP_COPY_SECOND    5'h1b
`define SCID_OP_TOP_TO_RET     5'h1c
`define SCID_OP_TOP_TO_ADDR    5'h1d
`define SCID_OP_SKIP_OP        5'h1e
`define SCID_OP_DROP           5'h1f
`define SCID_BIT_CALL          15
`define SCID_PAGE_LSB          10
`define SCID_STACK_DEPTH       8
`define SCID_STACK_PTR_W       3
`define SCID_RESET_PC          16'h0000
`endif

// [scid_stack.v]
`timescale 1ns/1ps
`default_nettype none
`include "scid_consts.vh"
module scid_stack (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        push,
  input  wire        pop,
  input  wire [15:0] din,
  output wire [15:0] top
);
  reg [15:0] cell_reg [0:`SCID_STACK_DEPTH-1];
  reg [`SCID_STACK_PTR_W-1:0] ptr_reg;
  // Circular storage: overflow silently wraps, like a hardware stack
  assign top = cell_reg[ptr_reg];
  genvar i;
  generate
    for (i = 0; i < `SCID_STACK_DEPTH; i = i + 1) begin : g_cell
      localparam [`SCID_STACK_PTR_W-1:0] CELL_IDX = i;
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          cell_reg[i] <= 16'h0000;
        end else if (push && !pop &&
                     ptr_reg + 3'h1 == CELL_IDX) begin
          cell_reg[i] <= din;
        end
      end
    end
  endgenerate
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ptr_reg <= {`SCID_STACK_PTR_W{1'b0}};
    end else if (push && !pop) begin
      ptr_reg <= ptr_reg + 3'h1;
    end else if (pop && !push) begin
      ptr_reg <= ptr_reg - 3'h1;
    end
  end
endmodule
`default_nettype wire

// [scid_core.v]
`timescale 1ns/1ps
`default_nettype none
`include "scid_consts.vh"
module scid_core (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire [15:0] mem_rdata,
  input  wire [4:0]  irq_lines,
  output reg  [15:0] mem_addr,
  output reg  [15:0] mem_wdata,
  output reg         mem_we,
  output wire [15:0] top_value,
  output wire        carry_flag,
  output wire        irq_enabled,
  output wire [1:0]  slot_index
);
  localparam ST_FETCH = 4'b0001;
  localparam ST_S1    = 4'b0010;
  localparam ST_S2    = 4'b0100;
  localparam ST_S3    = 4'b1000;

  reg  [3:0]  state_reg, state_next;
  reg  [15:0] pc_reg, pc_next;
  reg  [15:0] ir_reg, ir_next;
  reg  [15:0] t_reg, t_next;
  reg  [15:0] a_reg, a_next;
  reg  [15:0] r_reg, r_next;
  reg  [15:0] s_reg, s_next;
  reg         c_reg, c_next;
  reg         ie_reg, ie_next;
  reg         ds_push, ds_pop, rs_push, rs_pop;
  reg  [4:0]  code;
  reg         irq_seen_reg, irq_seen_next;
  reg  [4:0]  irq_s1_reg, irq_s2_reg;
  wire [15:0] ds_top, rs_top;
  wire [16:0] sum = {1'b0, t_reg} + {1'b0, s_reg};
  wire [16:0] prod_sum = a_reg[0] ? sum : {1'b0, t_reg};
  wire [15:0] page_target;
  wire [15:0] word_addr = pc_reg - 16'h0001;
  wire        is_long;

  assign top_value   = t_reg;
  assign carry_flag  = c_reg;
  assign irq_enabled = ie_reg;
  assign slot_index  = state_reg[1] ? 2'd1 : state_reg[2] ? 2'd2 :
                       state_reg[3] ? 2'd3 : 2'd0;
  assign page_target = {word_addr[15:`SCID_PAGE_LSB],
                        ir_reg[9:0]};
  // PC already points past the word; page of the word itself is PC-1
  assign is_long = (ir_reg[14:10] == `SCID_OP_JUMP_ALWAYS) ||
                   (ir_reg[14:10] == `SCID_OP_JUMP_IF_ZERO) ||
                   (ir_reg[14:10] == `SCID_OP_JUMP_IF_CARRY) ||
                   (ir_reg[14:10] == `SCID_OP_LOOP_NEXT);

  scid_stack u_dstack (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .push    (ds_push),
    .pop     (ds_pop),
    .din     (s_reg),
    .top     (ds_top)
  );
  scid_stack u_rstack (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .push    (rs_push),
    .pop     (rs_pop),
    .din     (r_reg),
    .top     (rs_top)
  );

  always @* begin
    state_next = state_reg;
    pc_next = pc_reg;
    ir_next = ir_reg;
    t_next = t_reg;
    a_next = a_reg;
    r_next = r_reg;
    s_next = s_reg;
    c_next = c_reg;
    ie_next = ie_reg;
    ds_push = 1'b0;
    ds_pop = 1'b0;
    rs_push = 1'b0;
    rs_pop = 1'b0;
    mem_addr = pc_reg;
    mem_wdata = t_reg;
    mem_we = 1'b0;
    irq_seen_next = 1'b0;
    code = ir_reg[14:10];
    case (state_reg)
      ST_S2: code = ir_reg[9:5];
      ST_S3: code = ir_reg[4:0];
      default: code = ir_reg[14:10];
    endcase
    case (state_reg)
      ST_FETCH: begin
        if (ie_reg && irq_s2_reg != 5'h00) begin
          // Vector taken as a call; the flag drops so it cannot re-enter
          rs_push = 1'b1;
          r_next = pc_reg;
          pc_next = {11'h000, irq_s2_reg};
          ie_next = 1'b0;
          irq_seen_next = 1'b1;
        end else begin
          ir_next = mem_rdata;
          pc_next = pc_reg + 16'h0001;
          state_next = ST_S1;
        end
      end
      default: begin
        if (state_reg == ST_S1) begin
          state_next = ST_S2;
        end else if (state_reg == ST_S2) begin
          state_next = ST_S3;
        end else begin
          state_next = ST_FETCH;
        end
        if (state_reg == ST_S1 && !ir_reg[`SCID_BIT_CALL]) begin
          rs_push = 1'b1;
          r_next = pc_reg;
          pc_next = {1'b0, ir_reg[14:0]};
          state_next = ST_FETCH;
        end else if (state_reg == ST_S1 && is_long) begin
          state_next = ST_FETCH;
          case (code)
            `SCID_OP_JUMP_ALWAYS: pc_next = page_target;
            `SCID_OP_JUMP_IF_ZERO:
              if (t_reg == 16'h0000) pc_next = page_target;
            `SCID_OP_JUMP_IF_CARRY:
              if (c_reg) pc_next = page_target;
            default: begin
              if (r_reg != 16'h0000) begin
                r_next = r_reg - 16'h0001;
                pc_next = page_target;
              end else begin
                r_next = rs_top;
                rs_pop = 1'b1;
              end
            end
          endcase
        end else begin
          case (code)
            `SCID_OP_SUB_EXIT: begin
              pc_next = r_reg;
              r_next = rs_top;
              rs_pop = 1'b1;
              state_next = ST_FETCH;
            end
            `SCID_OP_SKIP_OP: state_next = ST_FETCH;
            `SCID_OP_IRQ_ENABLE: ie_next = 1'b1;
            `SCID_OP_LOAD_VIA_ADDR, `SCID_OP_LOAD_ADDR_INC: begin
              mem_addr = a_reg;
              t_next = mem_rdata;
              s_next = t_reg;
              ds_push = 1'b1;
              if (code == `SCID_OP_LOAD_ADDR_INC)
                a_next = a_reg + 16'h0001;
            end
            `SCID_OP_LOAD_LITERAL: begin
              mem_addr = pc_reg;
              t_next = mem_rdata;
              s_next = t_reg;
              ds_push = 1'b1;
              pc_next = pc_reg + 16'h0001;
            end
            `SCID_OP_WRITE_VIA_ADDR, `SCID_OP_WRITE_ADDR_INC: begin
              mem_addr = a_reg;
              mem_we = 1'b1;
              t_next = s_reg;
              s_next = ds_top;
              ds_pop = 1'b1;
              if (code == `SCID_OP_WRITE_ADDR_INC)
                a_next = a_reg + 16'h0001;
            end
            `SCID_OP_INVERT_TOP: t_next = ~t_reg;
            `SCID_OP_SHIFT_UP: t_next = {t_reg[14:0], 1'b0};
            `SCID_OP_SHIFT_DOWN: t_next = {1'b0, t_reg[15:1]};
            `SCID_OP_BYTE_ROTATE: t_next = {t_reg[7:0], t_reg[15:8]};
            `SCID_OP_XOR, `SCID_OP_AND, `SCID_OP_ADD: begin
              if (code == `SCID_OP_XOR) t_next = t_reg ^ s_reg;
              else if (code == `SCID_OP_AND) t_next = t_reg & s_reg;
              else begin
                t_next = sum[15:0];
                c_next = sum[16];
              end
              s_next = ds_top;
              ds_pop = 1'b1;
            end
            `SCID_OP_PRODUCT_STEP: begin
              t_next = prod_sum[16:1];
              a_next = {prod_sum[0], a_reg[15:1]};
            end
            `SCID_OP_QUOTIENT_STEP: begin
              if (sum[16]) begin
                t_next = {sum[14:0], a_reg[15]};
                a_next = {a_reg[14:0], 1'b1};
              end else begin
                t_next = {t_reg[14:0], a_reg[15]};
                a_next = {a_reg[14:0], 1'b0};
              end
            end
            `SCID_OP_RET_TO_TOP: begin
              t_next = r_reg;
              r_next = rs_top;
              rs_pop = 1'b1;
              s_next = t_reg;
              ds_push = 1'b1;
            end
            `SCID_OP_TOP_TO_RET: begin
              r_next = t_reg;
              rs_push = 1'b1;
              t_next = s_reg;
              s_next = ds_top;
              ds_pop = 1'b1;
            end
            `SCID_OP_TOP_TO_ADDR: begin
              a_next = t_reg;
              t_next = s_reg;
              s_next = ds_top;
              ds_pop = 1'b1;
            end
            `SCID_OP_ADDR_TO_TOP: begin
              t_next = a_reg;
              s_next = t_reg;
              ds_push = 1'b1;
            end
            `SCID_OP_COPY_TOP: begin
              s_next = t_reg;
              ds_push = 1'b1;
            end
            `SCID_OP_COPY_SECOND: begin
              t_next = s_reg;
              s_next = t_reg;
              ds_push = 1'b1;
            end
            `SCID_OP_DROP: begin
              t_next = s_reg;
              s_next = ds_top;
              ds_pop = 1'b1;
            end
            default: t_next = t_reg;
          endcase
        end
      end
    endcase
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_FETCH;
      pc_reg <= `SCID_RESET_PC;
      ir_reg <= 16'h0000;
      t_reg <= 16'h0000;
      a_reg <= 16'h0000;
      r_reg <= 16'h0000;
      s_reg <= 16'h0000;
      c_reg <= 1'b0;
      ie_reg <= 1'b0;
      irq_seen_reg <= 1'b0;
      irq_s1_reg <= 5'h00;
      irq_s2_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      ir_reg <= ir_next;
      t_reg <= t_next;
      a_reg <= a_next;
      r_reg <= r_next;
      s_reg <= s_next;
      c_reg <= c_next;
      ie_reg <= ie_next;
      irq_seen_reg <= irq_seen_next;
      irq_s1_reg <= irq_lines;
      irq_s2_reg <= irq_s1_reg;
    end
  end
endmodule
`default_nettype wire

// [scid_core_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "scid_consts.vh"
module scid_core_asserts (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic [15:0] mem_rdata,
  input wire logic [4:0]  irq_lines,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic        mem_we,
  input wire logic [15:0] top_value,
  input wire logic        carry_flag,
  input wire logic        irq_enabled,
  input wire logic [1:0]  slot_index
);
  logic [15:0] ir_reg;
  logic [15:0] pc_reg;
  logic [4:0]  code;
  // Shadow of the fetched word; an interrupt fetch is never followed by a slot
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ir_reg <= 16'h0000;
      pc_reg <= 16'h0000;
    end else if (slot_index == 2'h0) begin
      ir_reg <= mem_rdata;
      pc_reg <= mem_addr;
    end
  end
  assign code = (slot_index == 2'h1) ? ir_reg[14:10] :
                (slot_index == 2'h2) ? ir_reg[9:5] : ir_reg[4:0];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_CALL: assert property (
    slot_index == 2'h0 && !irq_enabled && mem_rdata[15] == 1'b0 |=> ##1
    slot_index == 2'h0 && mem_addr == {1'b0, $past(mem_rdata[14:0], 2)})
    else $error("call target not fetched");
  AST_PAGE_JUMP: assert property (
    slot_index == 2'h1 && ir_reg[15] && code == `SCID_OP_JUMP_ALWAYS |=>
    slot_index == 2'h0 && mem_addr == {pc_reg[15:10], $past(ir_reg[9:0])})
    else $error("page jump target wrong");
  AST_SLOT_ORDER: assert property (
    (slot_index == 2'h1 || slot_index == 2'h2) && ir_reg[15] &&
    code >= 5'h06 && code != `SCID_OP_SKIP_OP |=>
    slot_index == $past(slot_index) + 2'h1)
    else $error("short code slot order broken");
  AST_WORD_END: assert property (slot_index == 2'h3 |=> slot_index == 2'h0)
    else $error("fourth slot not followed by fetch");
  AST_SKIP_END: assert property (
    slot_index != 2'h0 && ir_reg[15] && code == `SCID_OP_SKIP_OP |=>
    slot_index == 2'h0)
    else $error("skip did not end the word");
  AST_WRITE_STROBE: assert property (mem_we == (slot_index != 2'h0 &&
    ir_reg[15] &&
    (code == `SCID_OP_WRITE_VIA_ADDR || code == `SCID_OP_WRITE_ADDR_INC)))
    else $error("write strobe mismatch");
  AST_WRITE_DATA: assert property (mem_we |-> mem_wdata == top_value)
    else $error("write data not top");
  AST_INVERT: assert property (
    slot_index != 2'h0 && ir_reg[15] && code == `SCID_OP_INVERT_TOP |=>
    top_value == ~$past(top_value))
    else $error("invert wrong");
  AST_ROTATE: assert property (
    slot_index != 2'h0 && ir_reg[15] && code == `SCID_OP_BYTE_ROTATE |=>
    top_value == {$past(top_value[7:0]), $past(top_value[15:8])})
    else $error("byte rotate wrong");
  AST_LITERAL: assert property (
    slot_index != 2'h0 && ir_reg[15] && code == `SCID_OP_LOAD_LITERAL |=>
    top_value == $past(mem_rdata))
    else $error("literal not loaded");
endmodule
bind scid_core scid_core_asserts u_chk (.clk_sys(clk_sys), .resetn(resetn),
  .mem_rdata(mem_rdata), .irq_lines(irq_lines), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_we(mem_we), .top_value(top_value),
  .carry_flag(carry_flag), .irq_enabled(irq_enabled), .slot_index(slot_index));
`default_nettype wire

// [scid_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scid_mem_model (
  input wire logic        clk_sys,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic        mem_we,
  output logic [15:0]     mem_rdata
);
  logic [15:0] mem [0:65535];
  // Unloaded words read unknown, so a stray fetch shows up at once
  assign mem_rdata = mem[mem_addr];
  always @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule
`default_nettype wire

// [tb_stack_cpu_instruction_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
`include "scid_consts.vh"
module tb_stack_cpu_instruction_decoder;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  irq_lines = 5'h00;
  logic [15:0] mem_rdata;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] top_value;
  logic        mem_we;
  logic        carry_flag;
  logic        irq_enabled;
  logic [1:0]  slot_index;
  logic [31:0] wr_log [0:15];
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;
  int          n_wr = 0;
  always #50 clk_sys = ~clk_sys;
  scid_core u_dut (.clk_sys(clk_sys), .resetn(resetn),
    .mem_rdata(mem_rdata), .irq_lines(irq_lines), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .top_value(top_value),
    .carry_flag(carry_flag), .irq_enabled(irq_enabled),
    .slot_index(slot_index));
  scid_mem_model u_mem (.clk_sys(clk_sys), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic put(input logic [15:0] a, input logic [15:0] d);
    u_mem.mem[a] = d;
  endtask
  function automatic logic [15:0] sh(input logic [4:0] a, b, c);
    return {1'b1, a, b, c};
  endfunction
  function automatic logic [15:0] lj(input logic [4:0] op,
                                     input logic [9:0] off);
    return {1'b1, op, off};
  endfunction
  // Writes are logged mid-cycle, where the combinational strobe is settled
  always @(negedge clk_sys) begin
    if (resetn && mem_we === 1'b1) begin
      if (n_wr < 16) begin
        wr_log[n_wr] = {mem_addr, mem_wdata};
      end
      n_wr++;
    end
  end
  // Program needs about 130 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 1000) begin
      fail_count++;
      print_verdict;
    end
  end
  initial begin
    put(0, sh(`SCID_OP_LOAD_LITERAL, `SCID_OP_TOP_TO_ADDR, `SCID_OP_LOAD_LITERAL));
    put(1, 16'h0100);
    put(2, 16'h1234);
    put(3, sh(`SCID_OP_BYTE_ROTATE, `SCID_OP_WRITE_ADDR_INC, `SCID_OP_SKIP_OP));
    put(4, sh(`SCID_OP_LOAD_LITERAL, `SCID_OP_INVERT_TOP, `SCID_OP_WRITE_ADDR_INC));
    put(5, 16'h00f0);
    put(6, sh(`SCID_OP_LOAD_LITERAL, `SCID_OP_LOAD_LITERAL, `SCID_OP_ADD));
    put(7, 16'h8001);
    put(8, 16'h8003);
    put(9, lj(`SCID_OP_JUMP_IF_CARRY, 10'h00b));
    put(10, sh(`SCID_OP_WRITE_VIA_ADDR, `SCID_OP_SKIP_OP, `SCID_OP_SKIP_OP));
    put(11, sh(`SCID_OP_WRITE_ADDR_INC, `SCID_OP_LOAD_LITERAL, `SCID_OP_SKIP_OP));
    put(12, 16'h0000);
    put(13, lj(`SCID_OP_JUMP_IF_ZERO, 10'h00f));
    put(14, sh(`SCID_OP_WRITE_VIA_ADDR, `SCID_OP_SKIP_OP, `SCID_OP_SKIP_OP));
    put(15, sh(`SCID_OP_LOAD_LITERAL, `SCID_OP_COPY_TOP, `SCID_OP_SHIFT_UP));
    put(16, 16'h8421);
    put(17, sh(`SCID_OP_XOR, `SCID_OP_WRITE_ADDR_INC, `SCID_OP_SKIP_OP));
    put(18, 16'h001e);
    put(19, sh(`SCID_OP_WRITE_ADDR_INC, `SCID_OP_SKIP_OP, `SCID_OP_WRITE_VIA_ADDR));
    put(20, sh(`SCID_OP_LOAD_LITERAL, `SCID_OP_TOP_TO_RET, `SCID_OP_SKIP_OP));
    put(21, 16'h0002);
    put(22, sh(`SCID_OP_LOAD_LITERAL, `SCID_OP_WRITE_ADDR_INC, `SCID_OP_SKIP_OP));
    put(23, 16'h0077);
    put(24, lj(`SCID_OP_LOOP_NEXT, 10'h016));
    put(25, sh(`SCID_OP_ADDR_TO_TOP, `SCID_OP_WRITE_ADDR_INC, `SCID_OP_SKIP_OP));
    put(26, sh(`SCID_OP_IRQ_ENABLE, `SCID_OP_SKIP_OP, `SCID_OP_SKIP_OP));
    put(27, lj(`SCID_OP_JUMP_ALWAYS, 10'h01b));
    put(28, sh(`SCID_OP_LOAD_LITERAL, `SCID_OP_WRITE_VIA_ADDR, `SCID_OP_SUB_EXIT));
    put(29, 16'h0ace);
    put(30, sh(`SCID_OP_LOAD_LITERAL, `SCID_OP_SUB_EXIT, `SCID_OP_WRITE_VIA_ADDR));
    put(31, 16'h5a5a);
    repeat (3) @(posedge clk_sys);
    #10;
    resetn = 1'b1;
    irq_lines = 5'h1c;
    while (n_wr < 10) @(posedge clk_sys);
    repeat (20) @(posedge clk_sys);
    check(wr_log[0], 32'h0100_3412);
    check(wr_log[1], 32'h0101_ff0f);
    check(wr_log[2], 32'h0102_0004);
    check(wr_log[3], 32'h0103_8c63);
    check(wr_log[4], 32'h0104_5a5a);
    check(wr_log[5], 32'h0105_0077);
    check(wr_log[6], 32'h0106_0077);
    check(wr_log[7], 32'h0107_0077);
    check(wr_log[8], 32'h0108_0108);
    check(wr_log[9], 32'h0109_0ace);
    check(n_wr, 32'h0000_000a);
    check({31'h0, irq_enabled}, 32'h0000_0000);
    check({31'h0, carry_flag}, 32'h0000_0001);
    // Second run after a mid-run reset; memory keeps the first run's data
    @(posedge clk_sys);
    #10;
    resetn = 1'b0;
    irq_lines = 5'h00;
    put(0, sh(`SCID_OP_LOAD_LITERAL, `SCID_OP_TOP_TO_ADDR,
              `SCID_OP_LOAD_ADDR_INC));
    put(1, 16'h0100);
    put(2, sh(`SCID_OP_LOAD_VIA_ADDR, `SCID_OP_AND, `SCID_OP_SHIFT_DOWN));
    put(3, sh(`SCID_OP_WRITE_ADDR_INC, `SCID_OP_SKIP_OP, `SCID_OP_SKIP_OP));
    put(4, sh(`SCID_OP_LOAD_LITERAL, `SCID_OP_LOAD_LITERAL,
              `SCID_OP_TOP_TO_ADDR));
    put(5, 16'h0003);
    put(6, 16'h0005);
    put(7, sh(`SCID_OP_LOAD_LITERAL, `SCID_OP_PRODUCT_STEP,
              `SCID_OP_WRITE_ADDR_INC));
    put(8, 16'h0000);
    put(9, sh(`SCID_OP_LOAD_LITERAL, `SCID_OP_QUOTIENT_STEP,
              `SCID_OP_WRITE_ADDR_INC));
    put(10, 16'hffff);
    put(11, lj(`SCID_OP_JUMP_ALWAYS, 10'h00b));
    repeat (3) @(posedge clk_sys);
    #10;
    resetn = 1'b1;
    while (n_wr < 13) @(posedge clk_sys);
    repeat (5) @(posedge clk_sys);
    check(wr_log[10], 32'h0101_1a01);
    check(wr_log[11], 32'h8002_0001);
    check(wr_log[12], 32'h0007_0005);
    check(n_wr, 32'h0000_000d);
    print_verdict;
  end
endmodule
`default_nettype wire
